// ### hw/lss_sequencer.sv
// lamp strike, fault entry and burst source sequencer
`timescale 1ns/100ps
module lss_sequencer #(
  parameter int WAIT_SCALE  = 1024,
  parameter int PWM_TIMEOUT = 65535
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // enable and programming
  input  wire logic                 enable,
  input  wire logic [15:0]          nominal_period,
  input  wire logic [7:0]           sweep_timer_capacitor,
  input  wire logic [7:0]           current_level_input,
  // feedback and protection
  input  wire logic                 current_reached,
  input  wire logic                 voltage_reached,
  input  wire logic [7:0]           lamp_voltage_sense,
  input  wire logic [7:0]           voltage_reg_level,
  input  wire logic signed [7:0]    aux_comp_input,
  input  wire logic signed [7:0]    aux_comp_ref,
  input  wire logic                 over_temp,
  // sync and burst
  input  wire logic [7:0]           phase_control_input,
  input  wire logic                 phase_burst_mode,
  input  wire logic [15:0]          burst_freq_capacitor,
  input  wire logic [7:0]           burst_duty_input,
  input  wire logic                 duty_tied_high,
  input  wire logic                 burst_pwm_input,
  // power stage
  output logic                      switching_on,
  output logic [16:0]               switch_period,
  output logic                      voltage_reg_active,
  output logic [7:0]                current_setpoint,
  // oscillator sync
  output logic                      sync_lock_en,
  output lss_pkg::lss_sync_t        sync_mode,
  output logic [7:0]                osc_phase_deg,
  // burst
  output logic                      burst_on,
  output logic [8:0]                burst_phase_deg,
  // fault pin, open drain
  output logic                      fault_out,
  output logic                      fault_oe_n
);

  typedef struct packed {
    lss_pkg::lss_state_t st;
    logic                en_q;
    logic [16:0]         period;
    logic [7:0]          step_cnt;
    logic [23:0]         wait_cnt;
    logic                pwm_q;
    logic [15:0]         meas_cnt;
    logic [15:0]         ext_per;
    logic [15:0]         ext_hi;
    logic [15:0]         pwm_seen;
    logic [15:0]         lf_cnt;
    logic                burst;
    logic [7:0]          cur_set;
  } lss_reg_t;

  lss_reg_t s;
  lss_reg_t next_s;

  function automatic logic is_active(input lss_pkg::lss_state_t st);
    is_active = (st == lss_pkg::LSS_SWEEP) || (st == lss_pkg::LSS_WAIT) ||
                (st == lss_pkg::LSS_RUN);
  endfunction

  logic        rise;
  logic        ovp;
  logic        aux_trip;
  logic        flt;
  logic        pwm_rise;
  logic        pwm_fall;
  logic        ext_active;
  logic        ph_sync;
  logic [23:0] wait_limit;
  logic [10:0] ovp_lhs;
  logic [10:0] ovp_rhs;
  logic [15:0] lf_per;
  logic [23:0] duty_prod;
  logic [22:0] delay_prod;
  logic [15:0] delay;
  logic [15:0] rel;
  logic [16:0] sweep_end;
  logic        b_indep;
  logic        b_phase;

  always_comb begin
    rise       = enable & ~s.en_q;
    ovp_lhs    = 11'(lamp_voltage_sense * lss_pkg::OVP_DEN);
    ovp_rhs    = 11'(voltage_reg_level * lss_pkg::OVP_NUM);
    ovp        = ovp_lhs > ovp_rhs;
    aux_trip   = aux_comp_input > aux_comp_ref;
    flt        = ovp | aux_trip | over_temp;
    pwm_rise   = burst_pwm_input & ~s.pwm_q;
    pwm_fall   = ~burst_pwm_input & s.pwm_q;
    ext_active = (s.pwm_seen != 16'h0000) | duty_tied_high;
    ph_sync    = phase_control_input <= lss_pkg::PH_FULL;
    wait_limit = 24'(sweep_timer_capacitor * WAIT_SCALE);
    sweep_end  = {nominal_period, 1'b0};
    lf_per     = (phase_burst_mode & ext_active) ? s.ext_per
                                                 : burst_freq_capacitor;
    duty_prod  = burst_freq_capacitor * burst_duty_input;
    b_indep    = s.lf_cnt < duty_prod[23:lss_pkg::DUTY_SHIFT];
    delay_prod = 23'(s.ext_per * phase_control_input);
    delay      = ph_sync ? delay_prod[22:lss_pkg::PH_SHIFT] : 16'h0000;
    rel        = (s.lf_cnt >= delay) ? 16'(s.lf_cnt - delay)
                                     : 16'(s.lf_cnt + s.ext_per - delay);
    b_phase    = rel < s.ext_hi;
  end

  always_comb begin
    next_s       = s;
    next_s.en_q  = enable;
    next_s.pwm_q = burst_pwm_input;
    case (s.st)
      lss_pkg::LSS_IDLE: begin
        if (rise) begin
          next_s.st       = lss_pkg::LSS_SWEEP;
          next_s.period   = {1'b0, nominal_period[15:1]};
          next_s.step_cnt = 8'h00;
          next_s.wait_cnt = 24'h000000;
        end
      end
      lss_pkg::LSS_SWEEP: begin
        if (flt) begin
          next_s.st = lss_pkg::LSS_FAULT;
        end else if (current_reached) begin
          next_s.st     = lss_pkg::LSS_RUN;
          next_s.period = {1'b0, nominal_period};
        end else if (voltage_reached) begin
          next_s.st       = lss_pkg::LSS_WAIT;
          next_s.wait_cnt = 24'h000000;
        end else if (s.step_cnt >= sweep_timer_capacitor) begin
          next_s.step_cnt = 8'h00;
          if (s.period < sweep_end) begin
            next_s.period = 17'(s.period + 17'h00001);
          end
        end else begin
          next_s.step_cnt = 8'(s.step_cnt + 8'h01);
        end
      end
      lss_pkg::LSS_WAIT: begin
        if (flt) begin
          next_s.st = lss_pkg::LSS_FAULT;
        end else if (current_reached) begin
          next_s.st     = lss_pkg::LSS_RUN;
          next_s.period = {1'b0, nominal_period};
        end else if (s.wait_cnt + 24'h000001 >= wait_limit) begin
          next_s.st = lss_pkg::LSS_FAULT;
        end else begin
          next_s.wait_cnt = 24'(s.wait_cnt + 24'h000001);
        end
      end
      lss_pkg::LSS_RUN: begin
        if (flt) begin
          next_s.st = lss_pkg::LSS_FAULT;
        end
      end
      lss_pkg::LSS_FAULT: begin
        next_s.st = lss_pkg::LSS_FAULT;
      end
      default: begin
        next_s.st = lss_pkg::LSS_IDLE;
      end
    endcase
    if (!enable) begin
      next_s.st = lss_pkg::LSS_IDLE;
    end

    // external pwm detection and measurement
    next_s.meas_cnt = 16'(s.meas_cnt + 16'h0001);
    if (pwm_rise) begin
      next_s.ext_per  = 16'(s.meas_cnt + 16'h0001);
      next_s.meas_cnt = 16'h0000;
    end
    if (pwm_fall) begin
      next_s.ext_hi = 16'(s.meas_cnt + 16'h0001);
    end
    if (pwm_rise | pwm_fall) begin
      next_s.pwm_seen = 16'(PWM_TIMEOUT);
    end else if (s.pwm_seen != 16'h0000) begin
      next_s.pwm_seen = 16'(s.pwm_seen - 16'h0001);
    end

    // low frequency oscillator, pulled into lock by pwm rising edges in phase burst mode
    if (phase_burst_mode & pwm_rise) begin
      next_s.lf_cnt = 16'h0000;
    end else if (s.lf_cnt + 16'h0001 >= lf_per) begin
      next_s.lf_cnt = 16'h0000;
    end else begin
      next_s.lf_cnt = 16'(s.lf_cnt + 16'h0001);
    end

    // burst source selection, only in current regulation
    if (s.st != lss_pkg::LSS_RUN) begin
      next_s.burst = 1'b1;
    end else if (phase_burst_mode & ext_active) begin
      next_s.burst = b_phase;
    end else if (ext_active) begin
      next_s.burst = burst_pwm_input;
    end else begin
      next_s.burst = b_indep;
    end
    next_s.cur_set = next_s.burst ? current_level_input : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s          <= '0;
      s.st       <= lss_pkg::LSS_IDLE;
      s.lf_cnt   <= lss_pkg::RST_LF_PERIOD;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign switching_on       = is_active(s.st);
  assign switch_period      = s.period;
  assign voltage_reg_active = s.st == lss_pkg::LSS_WAIT;
  assign current_setpoint   = s.cur_set;
  assign sync_lock_en       = (s.st == lss_pkg::LSS_RUN) & ph_sync;
  assign sync_mode          = !ph_sync ? lss_pkg::LSS_SYNC_REF :
                              (phase_control_input == 8'h00) ? lss_pkg::LSS_SYNC_DIRECT :
                              lss_pkg::LSS_SYNC_PHASE;
  assign osc_phase_deg      = ph_sync ? 8'((16'(phase_control_input) * lss_pkg::PH_DEG_HALF)
                                           >> lss_pkg::PH_SHIFT) : 8'h00;
  assign burst_phase_deg    = ph_sync ? 9'((16'(phase_control_input) * lss_pkg::PH_DEG_FULL)
                                           >> lss_pkg::PH_SHIFT) : 9'h000;
  assign burst_on           = s.burst;
  assign fault_out          = 1'b0;
  assign fault_oe_n         = s.st != lss_pkg::LSS_FAULT;

  // checks
  chk_ovp_fault: assert property (@(posedge clk) disable iff (!rstn)
    is_active(s.st) && enable && ovp |=> s.st == lss_pkg::LSS_FAULT)
    else $error("overvoltage did not fault");
  chk_aux_fault: assert property (@(posedge clk) disable iff (!rstn)
    is_active(s.st) && enable && aux_trip |=> fault_oe_n == 1'b0)
    else $error("standalone comparator did not fault");
  chk_temp_fault: assert property (@(posedge clk) disable iff (!rstn)
    is_active(s.st) && enable && over_temp |=> !switching_on)
    else $error("overtemperature did not stop switching");
  chk_strike_start: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_IDLE && rise
    |=> s.st == lss_pkg::LSS_SWEEP && s.period == {1'b0, $past(nominal_period) >> 1})
    else $error("strike did not start at double frequency");
  chk_lock_run: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_SWEEP && enable && !flt && current_reached
    |=> s.st == lss_pkg::LSS_RUN && s.period == {1'b0, $past(nominal_period)})
    else $error("current lock did not switch to nominal");
  chk_vreg_halt: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_WAIT ##1 s.st == lss_pkg::LSS_WAIT |-> $stable(s.period))
    else $error("sweep moved during voltage regulation");
  chk_sync_gate: assert property (@(posedge clk) disable iff (!rstn)
    sync_lock_en |-> s.st == lss_pkg::LSS_RUN && burst_on == s.burst)
    else $error("sync enabled outside current regulation");
  chk_wait_expire: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_WAIT && enable && !flt && !current_reached &&
    s.wait_cnt + 24'h000001 >= wait_limit |=> s.st == lss_pkg::LSS_FAULT)
    else $error("wait timer expiry did not fault");
  chk_fault_hold: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_FAULT && enable |=> s.st == lss_pkg::LSS_FAULT)
    else $error("fault released without enable toggle");
  chk_burst_ext: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_RUN && enable && !flt && !phase_burst_mode && duty_tied_high
    |=> burst_on == $past(burst_pwm_input))
    else $error("external pwm did not drive bursts");

  // state and fault pin checks
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_IDLE |-> !switching_on)
    else $error("switching while idle");
  chk_fault_stop: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_FAULT |-> !switching_on)
    else $error("switching while in fault");
  chk_fault_pin: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_FAULT |-> !fault_oe_n && fault_out == 1'b0)
    else $error("fault pin not pulled low in fault");
  chk_pin_release: assert property (@(posedge clk) disable iff (!rstn)
    s.st != lss_pkg::LSS_FAULT |-> fault_oe_n)
    else $error("fault pin driven outside fault");
  chk_enable_low: assert property (@(posedge clk) disable iff (!rstn)
    !enable |=> s.st == lss_pkg::LSS_IDLE)
    else $error("enable low did not return to idle");

  // strike sequence checks
  chk_sweep_ceiling: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_SWEEP |-> s.period <= sweep_end)
    else $error("sweep went past half frequency");
  chk_sweep_step: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_SWEEP ##1 s.st == lss_pkg::LSS_SWEEP
    |-> s.period == $past(s.period) || s.period == 17'($past(s.period) + 17'h00001))
    else $error("sweep step not downward by one");
  chk_vreg_enter: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_SWEEP && enable && !flt && !current_reached && voltage_reached
    |=> s.st == lss_pkg::LSS_WAIT && voltage_reg_active)
    else $error("voltage reached did not start wait");
  chk_wait_recover: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_WAIT && enable && !flt && current_reached
    |=> s.st == lss_pkg::LSS_RUN)
    else $error("current lock in wait did not resume");
  chk_run_period: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_RUN ##1 s.st == lss_pkg::LSS_RUN |-> $stable(s.period))
    else $error("period moved in current regulation");
  chk_strike_sync: assert property (@(posedge clk) disable iff (!rstn)
    s.st != lss_pkg::LSS_RUN |-> !sync_lock_en)
    else $error("sync enabled during strike");
  chk_strike_burst: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_SWEEP || s.st == lss_pkg::LSS_WAIT |-> burst_on)
    else $error("burst dimming active during strike");

  // current setpoint checks
  chk_setpoint_on: assert property (@(posedge clk) disable iff (!rstn)
    burst_on |-> current_setpoint == $past(current_level_input))
    else $error("setpoint does not follow current level");
  chk_setpoint_off: assert property (@(posedge clk) disable iff (!rstn)
    !burst_on |-> current_setpoint == 8'h00)
    else $error("setpoint not zero between bursts");

  // sync mode checks
  chk_sync_ref: assert property (@(posedge clk) disable iff (!rstn)
    phase_control_input > lss_pkg::PH_FULL |-> sync_mode == lss_pkg::LSS_SYNC_REF && !sync_lock_en)
    else $error("reference mode not selected");
  chk_sync_direct: assert property (@(posedge clk) disable iff (!rstn)
    phase_control_input == 8'h00 |-> sync_mode == lss_pkg::LSS_SYNC_DIRECT && osc_phase_deg == 8'h00)
    else $error("direct lock mode not selected");
  chk_osc_full: assert property (@(posedge clk) disable iff (!rstn)
    phase_control_input == lss_pkg::PH_FULL |-> osc_phase_deg == 8'(lss_pkg::PH_DEG_HALF))
    else $error("oscillator phase wrong at full scale");
  chk_burst_full: assert property (@(posedge clk) disable iff (!rstn)
    phase_control_input == lss_pkg::PH_FULL |-> burst_phase_deg == lss_pkg::PH_DEG_FULL)
    else $error("burst phase wrong at full scale");

  // burst source checks
  chk_indep_burst: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_RUN && enable && !flt && !ext_active |=> burst_on == $past(b_indep))
    else $error("internal burst not used");
  chk_burst_follow: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_RUN && enable && !flt && !phase_burst_mode && ext_active
    |=> burst_on == $past(burst_pwm_input))
    else $error("detected pwm did not override bursts");
  chk_phase_burst: assert property (@(posedge clk) disable iff (!rstn)
    s.st == lss_pkg::LSS_RUN && enable && !flt && phase_burst_mode && ext_active
    |=> burst_on == $past(b_phase))
    else $error("phase shifted burst not used");
  chk_lf_lock: assert property (@(posedge clk) disable iff (!rstn)
    phase_burst_mode && pwm_rise |=> s.lf_cnt == 16'h0000)
    else $error("burst oscillator not pulled to pwm edge");

endmodule

// ### hw/lss_pkg.sv
// constants and types for the lamp strike, fault and burst sequencer
// Operation
// - lamp voltage peak 20% over level faults
// - standalone comparator above reference faults, unrectified
// - excessive die temperature faults
// - direct and phase-shifted oscillator sync lock
// - phase input 0-2 V maps 0-180 degrees
// - current level input sets lamp current
// - internal burst period and proportional duty
// - detected external burst pwm overrides internal
// - phase burst keeps pwm, delays 0-360
// - burst oscillator locks to external pwm in phase burst mode
// - strike on enable; dimming, sync inhibited
// - strike starts double frequency, sweeps half
// - current lock: nominal frequency, enable features
// - voltage reached: halt sweep, start wait
// - current lock during wait resumes operation
// - wait expiry stops switching, faults
// - any fault disables the device
// - fault pin open drain, low on fault
package lss_pkg;

  // sequencer states, gray coded along idle-sweep-run
  typedef enum logic [2:0] {
    LSS_IDLE  = 3'h0,
    LSS_SWEEP = 3'h1,
    LSS_RUN   = 3'h3,
    LSS_WAIT  = 3'h2,
    LSS_FAULT = 3'h6
  } lss_state_t;

  // oscillator sync mode
  typedef enum logic [1:0] {
    LSS_SYNC_REF    = 2'h0,
    LSS_SYNC_DIRECT = 2'h1,
    LSS_SYNC_PHASE  = 2'h2
  } lss_sync_t;

  // overvoltage ratio: trip when peak * 5 > level * 6
  localparam logic [2:0] OVP_NUM = 3'h6;
  localparam logic [2:0] OVP_DEN = 3'h5;

  // phase control code for 2 V, as a shift (code 0x80)
  localparam int         PH_SHIFT    = 7;
  localparam logic [7:0] PH_FULL     = 8'h80;
  localparam logic [8:0] PH_DEG_HALF = 9'h0B4;
  localparam logic [8:0] PH_DEG_FULL = 9'h168;

  // duty code full scale as a shift
  localparam int DUTY_SHIFT = 8;

  // reset values
  localparam logic [15:0] RST_LF_PERIOD = 16'h0000;

endpackage

// ### sim/lss_lamp_model.sv
// lamp power stage, feedback and external burst pwm model
`timescale 1ns/100ps
module lss_lamp_model #(
  parameter int STRIKE_CYC = 60
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // stage control
  input  wire logic switching_on,
  input  wire logic open_lamp,
  input  wire logic pwm_en,
  // feedback and pwm
  output logic      current_reached,
  output logic      voltage_reached,
  output logic      burst_pwm_input
);
  logic [7:0] lit_cnt;
  logic [1:0] pwm_cnt;
  // lamp only conducts while the bridge switches; an open lamp never does
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lit_cnt <= 8'h00;
      pwm_cnt <= 2'h0;
      current_reached <= 1'b0;
      voltage_reached <= 1'b0;
      burst_pwm_input <= 1'b0;
    end else begin
      lit_cnt <= (switching_on && lit_cnt != 8'hFF) ? lit_cnt + 8'h01 : (switching_on ? lit_cnt : 8'h00);
      current_reached <= switching_on && !open_lamp && lit_cnt >= STRIKE_CYC;
      voltage_reached <= switching_on && open_lamp;
      pwm_cnt <= pwm_en ? pwm_cnt + 2'h1 : 2'h0;
      if (!pwm_en) burst_pwm_input <= 1'b0;
      else if (pwm_cnt == 2'h3) burst_pwm_input <= !burst_pwm_input;
    end
  end
endmodule

// ### sim/lss_sequencer_tb.sv
// self-checking bench for the lamp strike, fault and burst sequencer
`timescale 1ns/100ps
module lss_sequencer_tb;
  logic clk, rstn, enable, over_temp, phase_burst_mode, duty_tied_high;
  logic open_lamp, pwm_en, current_reached, voltage_reached, burst_pwm_input;
  logic [15:0] nominal_period, burst_freq_capacitor;
  logic [7:0]  sweep_timer_capacitor, current_level_input, lamp_voltage_sense;
  logic [7:0]  voltage_reg_level, phase_control_input, burst_duty_input;
  logic signed [7:0] aux_comp_input, aux_comp_ref;
  logic        switching_on, voltage_reg_active, sync_lock_en, burst_on, fault_out, fault_oe_n;
  logic [16:0] switch_period;
  logic [7:0]  current_setpoint, osc_phase_deg;
  logic [8:0]  burst_phase_deg;
  lss_pkg::lss_sync_t sync_mode;
  wire logic   fault_pin;
  int          err_total, n_compared;
  // pull-up on the open-drain fault line
  assign fault_pin = fault_oe_n ? 1'b1 : fault_out;
  lss_sequencer #(.WAIT_SCALE(4), .PWM_TIMEOUT(64)) dut (.clk, .rstn, .enable, .nominal_period,
    .sweep_timer_capacitor, .current_level_input, .current_reached, .voltage_reached,
    .lamp_voltage_sense, .voltage_reg_level, .aux_comp_input, .aux_comp_ref, .over_temp,
    .phase_control_input, .phase_burst_mode, .burst_freq_capacitor, .burst_duty_input,
    .duty_tied_high, .burst_pwm_input, .switching_on, .switch_period, .voltage_reg_active,
    .current_setpoint, .sync_lock_en, .sync_mode, .osc_phase_deg, .burst_on, .burst_phase_deg,
    .fault_out, .fault_oe_n);
  lss_lamp_model #(.STRIKE_CYC(60)) lamp (.clk, .rstn, .switching_on, .open_lamp, .pwm_en,
    .current_reached, .voltage_reached, .burst_pwm_input);
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic restart();
    @(posedge clk);
    enable <= 1'b0;
    @(posedge clk);
    enable <= 1'b1;
  endtask
  task automatic wait_run();
    int i;
    cyc(1);
    for (i = 0; i < 200 && sync_lock_en !== 1'b1; i++) @(negedge clk);
    check(sync_lock_en, 1'b1);
  endtask
  task automatic t_strike();
    restart();
    cyc(2);
    check(switch_period, 17'h00008);
    check(sync_lock_en, 1'b0);
    check(burst_on, 1'b1);
    cyc(40);
    check(switch_period, 17'h00020);
    check(current_setpoint, 8'hA5);
    wait_run();
    check(switch_period, 17'h00010);
  endtask
  task automatic t_wait();
    logic [16:0] p;
    @(posedge clk);
    sweep_timer_capacitor <= 8'h03;
    open_lamp <= 1'b1;
    restart();
    cyc(4);
    p = switch_period;
    cyc(8);
    check(voltage_reg_active, 1'b1);
    check(switch_period, p);
    check(fault_pin, 1'b1);
    cyc(8);
    check(fault_pin, 1'b0);
    check(switching_on, 1'b0);
    cyc(20);
    check(fault_pin, 1'b0);
    @(posedge clk);
    enable <= 1'b0;
    open_lamp <= 1'b0;
    cyc(2);
    check(fault_pin, 1'b1);
    @(posedge clk);
    enable <= 1'b1;
    cyc(2);
    check(switch_period, 17'h00008);
  endtask
  task automatic t_recover();
    @(posedge clk);
    sweep_timer_capacitor <= 8'h28;
    open_lamp <= 1'b1;
    restart();
    cyc(10);
    check(voltage_reg_active, 1'b1);
    @(posedge clk);
    open_lamp <= 1'b0;
    wait_run();
    check(voltage_reg_active, 1'b0);
    check(fault_pin, 1'b1);
  endtask
  task automatic t_faults();
    int k;
    for (k = 0; k < 3; k++) begin
      restart();
      wait_run();
      @(posedge clk);
      lamp_voltage_sense <= 8'h78;
      aux_comp_input <= 8'h9C;
      cyc(3);
      check(fault_pin, 1'b1);
      @(posedge clk);
      if (k == 0) lamp_voltage_sense <= 8'h79;
      if (k == 1) aux_comp_input <= 8'h33;
      if (k == 2) over_temp <= 1'b1;
      cyc(2);
      check(fault_pin, 1'b0);
      check(switching_on, 1'b0);
      @(posedge clk);
      lamp_voltage_sense <= 8'h00;
      aux_comp_input <= 8'h00;
      over_temp <= 1'b0;
    end
  endtask
  task automatic t_burst();
    int i, highs;
    logic prev;
    @(posedge clk);
    burst_duty_input <= 8'h80;
    restart();
    wait_run();
    cyc(16);
    highs = 0;
    for (i = 0; i < 16; i++) begin
      cyc(1);
      highs += burst_on;
      check(current_setpoint, burst_on ? 8'hA5 : 8'h00);
    end
    check(highs, 8);
    @(posedge clk);
    burst_duty_input <= 8'h00;
    cyc(20);
    check(burst_on, 1'b0);
    @(posedge clk);
    pwm_en <= 1'b1;
    cyc(20);
    prev = burst_pwm_input;
    for (i = 0; i < 16; i++) begin
      cyc(1);
      check(burst_on, prev);
      prev = burst_pwm_input;
    end
    @(posedge clk);
    pwm_en <= 1'b0;
    burst_duty_input <= 8'hFF;
    duty_tied_high <= 1'b1;
    cyc(70);
    for (i = 0; i < 8; i++) begin
      cyc(1);
      check(burst_on, 1'b0);
    end
    @(posedge clk);
    duty_tied_high <= 1'b0;
  endtask
  task automatic t_phase();
    int i, highs;
    logic p1, p2;
    @(posedge clk);
    phase_burst_mode <= 1'b1;
    pwm_en <= 1'b1;
    cyc(40);
    highs = 0;
    p2 = burst_pwm_input;
    cyc(1);
    p1 = burst_pwm_input;
    for (i = 0; i < 16; i++) begin
      cyc(1);
      check(burst_on, !p2);
      highs += burst_on;
      p2 = p1;
      p1 = burst_pwm_input;
    end
    check(highs, 8);
    @(posedge clk);
    phase_burst_mode <= 1'b0;
    pwm_en <= 1'b0;
  endtask
  task automatic t_sync();
    logic [7:0] codes[4] = '{8'h00, 8'h40, 8'h80, 8'h90};
    logic [7:0] oscs[4] = '{8'h00, 8'h5A, 8'hB4, 8'h00};
    logic [8:0] bursts[3] = '{9'h000, 9'h0B4, 9'h168};
    logic [1:0] modes[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      phase_control_input <= codes[i];
      cyc(3);
      check(sync_mode, modes[i]);
      check(osc_phase_deg, oscs[i]);
      check(sync_lock_en, i < 3);
      if (i < 3) check(burst_phase_deg, bursts[i]);
    end
    @(posedge clk);
    phase_control_input <= 8'h40;
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    {rstn, enable, over_temp, phase_burst_mode, duty_tied_high, open_lamp, pwm_en} = 7'h00;
    err_total = 0;
    n_compared = 0;
    nominal_period = 16'h0010;
    burst_freq_capacitor = 16'h0010;
    sweep_timer_capacitor = 8'h00;
    current_level_input = 8'hA5;
    lamp_voltage_sense = 8'h00;
    voltage_reg_level = 8'h64;
    aux_comp_input = 8'h00;
    aux_comp_ref = 8'h32;
    phase_control_input = 8'h40;
    burst_duty_input = 8'hFF;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_strike();
    t_sync();
    t_wait();
    t_recover();
    t_faults();
    t_burst();
    t_phase();
    print_verdict();
  end
endmodule
